// [include/scsi_irq_pkg.sv]
// constants for the bus-controller interrupt logic
package scsi_irq_pkg;
	// register indices; each register is one aligned word, so its byte address is four times this
	localparam int IDX_ID_SELECT = 0;
	localparam int IDX_INIT_CMD  = 1;
	localparam int IDX_MODE      = 2;
	localparam int IDX_TGT_CMD   = 3;
	localparam int IDX_CTRL_VIEW = 4;
	localparam int IDX_DMA_STAT  = 5;
	localparam int IDX_IRQ_CLEAR = 7;
	// register byte addresses on the axi4-lite bus
	localparam logic [7:0] OFF_MODE      = 8'(IDX_MODE * 4);
	localparam logic [7:0] OFF_INIT_CMD  = 8'(IDX_INIT_CMD * 4);
	localparam logic [7:0] OFF_TGT_CMD   = 8'(IDX_TGT_CMD * 4);
	localparam logic [7:0] OFF_ID_SELECT = 8'(IDX_ID_SELECT * 4);
	localparam logic [7:0] OFF_CTRL_VIEW = 8'(IDX_CTRL_VIEW * 4);
	localparam logic [7:0] OFF_DMA_STAT  = 8'(IDX_DMA_STAT * 4);
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'(IDX_IRQ_CLEAR * 4);
	// mode register fields
	localparam int MODE_DMA     = 1;
	localparam int MODE_MON_BSY = 2;
	localparam int MODE_EOD_EN  = 3;
	localparam int MODE_PAR_EN  = 5;
	localparam int MODE_TGT     = 6;
	// initiator command fields
	localparam int ICMD_TEST    = 6;
	localparam int ICMD_RST     = 7;
	// status view fields
	localparam int STAT_EOD     = 7;
	localparam int STAT_PARERR  = 5;
	localparam int STAT_IRQ     = 4;
	localparam int STAT_PHASE   = 3;
	localparam int STAT_BSYERR  = 2;
	localparam int VIEW_RST     = 7;
	// reset values
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] ICMD_RST_V = 8'h00;
	localparam logic [7:0] TCMD_RST  = 8'h00;
	localparam logic [7:0] IDSEL_RST = 8'h00;
	// bus settle delay and minimum end of process time
	localparam int CLK_MHZ     = 250;
	localparam int SETTLE_NS   = 400;
	localparam int SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int EOP_MIN_CYC = 2;
endpackage

// [verilog/scsi_interrupt_logic.sv]
// interrupt causes, status views and axi4-lite registers of the bus controller
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1: interrupt output follows latch; enable dropped while test bit set
// RULE2: reading clear register clears request latch and error latches
// RULE3: six interrupt causes, most with enables
// RULE4: bus reset rising edge always interrupts, own or foreign drive
// RULE5: live reset line shown unlatched in control view bit 7
// RULE6: software infers bus reset when no other cause shows
// RULE7: selection needs select, id match, busy false one settle delay
// RULE8: software treats selection with io asserted as reselection
// RULE9: selection interrupt suppressed when identity_select_register is zero
// RULE10: loss of busy after busy inactive one settle delay
// RULE11: busy monitor off blocks loss of busy interrupt and latch
// RULE12: phase mismatch interrupt when dma mode, req, phase differs
// RULE13: phase match status bit is a continuous comparison
// RULE14: during mismatch ignore req and disable data drivers
// RULE15: phase mismatch unmaskable but only in dma mode
// RULE16: in dma mode parity checked on ack as target, req as initiator
// RULE17: parity latch set only with parity check enabled
// RULE18: end of process valid with dma ack and a strobe, min time
// RULE19: end of process outside strobes ignored
// RULE20: end of transfer latch set in dma mode, interrupts if enabled
// RULE21: end of transfer enable masks only the interrupt
// RULE22: end of transfer latch cleared only by clearing dma mode
// RULE23: clear read clears status bits 5, 4 and 2
// RULE24: busy error disables bus pins, clears dma mode, command bits 0-5
// RULE25: request latch set on first cause, held until clear read
module scsi_interrupt_logic #(
	parameter int SETTLE_CYC  = scsi_irq_pkg::SETTLE_CYC,
	parameter int EOP_MIN_CYC = scsi_irq_pkg::EOP_MIN_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        rst_line_i,
	input  wire logic        bsy_line_i,
	input  wire logic        req_line_i,
	input  wire logic        ack_line_i,
	input  wire logic        sel_line_i,
	input  wire logic        atn_line_i,
	input  wire logic        msg_line_i,
	input  wire logic        cd_line_i,
	input  wire logic        io_line_i,
	input  wire logic [7:0]  data_line_i,
	input  wire logic        parity_line_i,
	input  wire logic        end_of_process_in_i,
	input  wire logic        dma_ack_in_i,
	input  wire logic        io_read_strobe_i,
	input  wire logic        io_write_strobe_i,
	output logic             irq_o,
	output logic             irq_oe_o,
	output logic             rst_drive_o,
	output logic             bus_pins_en_o,
	output logic             data_drive_en_o,
	output logic             req_accept_o
);
	// both counters are eight bits wide
	if (SETTLE_CYC < 1 || SETTLE_CYC > 255
		|| EOP_MIN_CYC < 1 || EOP_MIN_CYC > 255) begin : g_bad_timing
		$error("scsi_interrupt_logic: timing count out of range");
	end

	logic [7:0] mode_reg;
	logic [7:0] icmd_reg;
	logic [7:0] tcmd_reg;
	logic [7:0] idsel_reg;
	logic       irq_reg;
	logic       par_err_reg;
	logic       bsy_err_reg;
	logic       eod_reg;
	logic       rst_prev_reg;
	logic       sel_prev_reg;
	logic [7:0] bsy_cnt_reg;
	logic [7:0] eop_cnt_reg;
	logic       bus_en_reg;

	// ---------------- axi4-lite slave ----------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic rd_fire;
	logic clr_read;
	logic [7:0] rd_byte;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign clr_read      = rd_fire && s_axi_araddr == scsi_irq_pkg::OFF_IRQ_CLEAR;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_reg)
					scsi_irq_pkg::OFF_MODE, scsi_irq_pkg::OFF_INIT_CMD,
					scsi_irq_pkg::OFF_TGT_CMD, scsi_irq_pkg::OFF_ID_SELECT:
						s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_lane0;
	assign wr_lane0 = wr_fire && w_strb_reg[0];

	// ---------------- status views ----------------
	logic phase_match;
	// continuous compare, not gated by dma mode or req
	assign phase_match = {msg_line_i, cd_line_i, io_line_i} == tcmd_reg[2:0]; // [RULE13]

	always_comb begin
		rd_byte = 8'h00;
		case (s_axi_araddr)
			scsi_irq_pkg::OFF_MODE:      rd_byte = mode_reg;
			scsi_irq_pkg::OFF_INIT_CMD:  rd_byte = icmd_reg;
			scsi_irq_pkg::OFF_TGT_CMD:   rd_byte = tcmd_reg;
			scsi_irq_pkg::OFF_ID_SELECT: rd_byte = idsel_reg;
			// live lines, unlatched
			scsi_irq_pkg::OFF_CTRL_VIEW: rd_byte = {rst_line_i, bsy_line_i, req_line_i,
				msg_line_i, cd_line_i, io_line_i, sel_line_i, parity_line_i}; // [RULE5]
			scsi_irq_pkg::OFF_DMA_STAT:  rd_byte = {eod_reg, 1'b0, par_err_reg, irq_reg,
				phase_match, bsy_err_reg, atn_line_i, ack_line_i};
			default:                     rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			case (s_axi_araddr)
				scsi_irq_pkg::OFF_MODE, scsi_irq_pkg::OFF_INIT_CMD,
				scsi_irq_pkg::OFF_TGT_CMD, scsi_irq_pkg::OFF_ID_SELECT,
				scsi_irq_pkg::OFF_CTRL_VIEW, scsi_irq_pkg::OFF_DMA_STAT,
				scsi_irq_pkg::OFF_IRQ_CLEAR: s_axi_rresp <= 2'b00;
				default:                     s_axi_rresp <= 2'b10;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------- cause detection ----------------
	logic bsy_settled;
	logic bsy_err_set;
	logic rst_edge;
	logic sel_cause;
	logic sel_cond;
	logic phase_cause;
	logic par_fault;
	logic par_cause;
	logic eop_valid;
	logic eod_set;
	logic any_cause;

	// counts cycles with busy inactive, saturating at the settle delay
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			bsy_cnt_reg <= 8'h00;
		else if (bsy_line_i)
			bsy_cnt_reg <= 8'h00;
		else if (bsy_cnt_reg < 8'(SETTLE_CYC))
			bsy_cnt_reg <= bsy_cnt_reg + 8'h01;
	end
	assign bsy_settled = bsy_cnt_reg == 8'(SETTLE_CYC);

	// one-shot on the cycle the settle count completes
	logic bsy_settled_prev_reg;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			bsy_settled_prev_reg <= 1'b0;
		else
			bsy_settled_prev_reg <= bsy_settled;
	end
	assign bsy_err_set = bsy_settled && !bsy_settled_prev_reg
		&& mode_reg[scsi_irq_pkg::MODE_MON_BSY]; // [RULE10] [RULE11]

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
		end else begin
			rst_prev_reg <= rst_line_i;
			sel_prev_reg <= sel_cond;
		end
	end
	// line level includes our own drive, so self-asserted reset interrupts too
	assign rst_edge = rst_line_i && !rst_prev_reg; // [RULE4]

	// empty identity_select_register means no match, so the cause is suppressed
	assign sel_cond  = sel_line_i && |(data_line_i & idsel_reg) && bsy_settled; // [RULE7] [RULE9]
	assign sel_cause = sel_cond && !sel_prev_reg;

	assign phase_cause = mode_reg[scsi_irq_pkg::MODE_DMA] && req_line_i && !phase_match; // [RULE12] [RULE15]

	// odd parity across data plus parity bit; target samples on ack, initiator on req
	assign par_fault = mode_reg[scsi_irq_pkg::MODE_DMA]
		&& (mode_reg[scsi_irq_pkg::MODE_TGT] ? ack_line_i : req_line_i)
		&& !(^{data_line_i, parity_line_i}); // [RULE16]
	assign par_cause = par_fault && mode_reg[scsi_irq_pkg::MODE_PAR_EN]; // [RULE17]

	// qualified end of process must hold for the minimum time inside a strobe
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			eop_cnt_reg <= 8'h00;
		else if (!(end_of_process_in_i && dma_ack_in_i
			&& (io_read_strobe_i || io_write_strobe_i))) // [RULE19]
			eop_cnt_reg <= 8'h00;
		else if (eop_cnt_reg < 8'(EOP_MIN_CYC))
			eop_cnt_reg <= eop_cnt_reg + 8'h01;
	end
	assign eop_valid = eop_cnt_reg == 8'(EOP_MIN_CYC - 1) && end_of_process_in_i
		&& dma_ack_in_i && (io_read_strobe_i || io_write_strobe_i); // [RULE18]
	assign eod_set = eop_valid && mode_reg[scsi_irq_pkg::MODE_DMA]; // [RULE20]

	// six causes; reset and phase mismatch have no enable
	assign any_cause = rst_edge || sel_cause || bsy_err_set || phase_cause || par_cause
		|| (eod_set && mode_reg[scsi_irq_pkg::MODE_EOD_EN]); // [RULE3] [RULE21]

	// ---------------- latches ----------------
	// set beats the clearing read in the same cycle
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_reg <= 1'b0;
		else if (any_cause)
			irq_reg <= 1'b1; // [RULE25]
		else if (clr_read)
			irq_reg <= 1'b0; // [RULE2]
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			par_err_reg <= 1'b0;
			bsy_err_reg <= 1'b0;
		end else begin
			if (par_cause)
				par_err_reg <= 1'b1;
			else if (clr_read)
				par_err_reg <= 1'b0; // [RULE23]
			if (bsy_err_set)
				bsy_err_reg <= 1'b1;
			else if (clr_read)
				bsy_err_reg <= 1'b0; // [RULE23]
		end
	end

	// only dropping dma mode clears it; the clearing read does not
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			eod_reg <= 1'b0;
		else if (!mode_reg[scsi_irq_pkg::MODE_DMA])
			eod_reg <= 1'b0; // [RULE22]
		else if (eod_set)
			eod_reg <= 1'b1;
	end

	// ---------------- control registers ----------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg  <= scsi_irq_pkg::MODE_RST;
			icmd_reg  <= scsi_irq_pkg::ICMD_RST_V;
			tcmd_reg  <= scsi_irq_pkg::TCMD_RST;
			idsel_reg <= scsi_irq_pkg::IDSEL_RST;
		end else begin
			if (wr_lane0 && aw_addr_reg == scsi_irq_pkg::OFF_MODE)
				mode_reg <= w_data_reg[7:0];
			if (wr_lane0 && aw_addr_reg == scsi_irq_pkg::OFF_INIT_CMD)
				icmd_reg <= w_data_reg[7:0];
			if (wr_lane0 && aw_addr_reg == scsi_irq_pkg::OFF_TGT_CMD)
				tcmd_reg <= w_data_reg[7:0];
			if (wr_lane0 && aw_addr_reg == scsi_irq_pkg::OFF_ID_SELECT)
				idsel_reg <= w_data_reg[7:0];
			// busy error wins over a simultaneous software write
			if (bsy_err_set) begin
				mode_reg[scsi_irq_pkg::MODE_DMA] <= 1'b0; // [RULE24]
				icmd_reg[5:0] <= 6'h00; // [RULE24]
			end
		end
	end

	// pins stay disabled after a busy error until software writes the initiator command register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			bus_en_reg <= 1'b1;
		else if (bsy_err_set)
			bus_en_reg <= 1'b0; // [RULE24]
		else if (wr_lane0 && aw_addr_reg == scsi_irq_pkg::OFF_INIT_CMD)
			bus_en_reg <= 1'b1;
	end

	// ---------------- outputs ----------------
	assign irq_o           = irq_reg; // [RULE1]
	assign irq_oe_o        = !icmd_reg[scsi_irq_pkg::ICMD_TEST]; // [RULE1]
	assign rst_drive_o     = icmd_reg[scsi_irq_pkg::ICMD_RST];
	assign bus_pins_en_o   = bus_en_reg;
	assign data_drive_en_o = bus_en_reg && phase_match; // [RULE14]
	assign req_accept_o    = req_line_i && phase_match; // [RULE14]

	// ---------------- assertions ----------------
	sequence clear_read_s;
		clr_read && !any_cause;
	endsequence

	irq_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		clear_read_s |=> !irq_reg) else $error("request latch not cleared by read"); // [RULE2]
	irq_set_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		any_cause |=> irq_reg && irq_o) else $error("request latch not set by cause"); // [RULE25]
	irq_tristate_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		icmd_reg[scsi_irq_pkg::ICMD_TEST] |-> !irq_oe_o) else $error("irq driven in test"); // [RULE1]
	bus_reset_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$rose(rst_line_i) |=> irq_reg) else $error("bus reset did not interrupt"); // [RULE4]
	sel_empty_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		idsel_reg == 8'h00 |-> !sel_cause) else $error("selection with empty id"); // [RULE9]
	busy_mask_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!mode_reg[scsi_irq_pkg::MODE_MON_BSY] && !bsy_err_reg && !bsy_err_set
		|=> !bsy_err_reg) else $error("busy error set while monitor off"); // [RULE11]
	busy_settle_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		bsy_err_set |-> !$past(bsy_line_i)) else $error("busy error too early"); // [RULE10]
	busy_abort_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		bsy_err_set |=> !mode_reg[scsi_irq_pkg::MODE_DMA] && icmd_reg[5:0] == 6'h00
		&& !bus_pins_en_o) else $error("busy error did not abort"); // [RULE24]
	phase_gate_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!phase_match |-> !data_drive_en_o && !req_accept_o) else $error("mismatch drives"); // [RULE14]
	eod_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		eod_reg && mode_reg[scsi_irq_pkg::MODE_DMA] |=> eod_reg)
		else $error("end of transfer lost in dma mode"); // [RULE22]
	par_gate_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!par_err_reg && !mode_reg[scsi_irq_pkg::MODE_PAR_EN] |=> !par_err_reg)
		else $error("parity latch set while disabled"); // [RULE17]
endmodule
`default_nettype wire

// [bench/scsi_peer_model.sv]
// far-side model: bus devices and dma controller facing the interrupt logic
`timescale 1ns/100ps
`default_nettype none
module scsi_peer_model (
	input  wire logic       clk_i,
	input  wire logic       rst_drive_i,
	output logic            rst_line_o,
	output var logic        bsy_o,
	output var logic        sel_o,
	output var logic        req_o,
	output var logic        msg_o,
	output var logic [7:0]  data_o,
	output var logic        parity_o,
	output var logic        ack_o,
	output var logic        atn_o,
	output var logic        cd_o,
	output var logic        io_o,
	output var logic        eop_o,
	output var logic        dma_ack_in_o,
	output var logic        ior_o,
	output var logic        iow_o
);
	logic peer_rst;

	// reset line is a wired-or, so our own assert-reset drive shows up on it too
	assign rst_line_o = peer_rst | rst_drive_i;

	initial begin
		peer_rst = 1'h0;
		bsy_o = 1'h1;
		sel_o = 1'h0;
		req_o = 1'h0;
		msg_o = 1'h0;
		data_o = 8'h00;
		parity_o = 1'h1;
		{eop_o, dma_ack_in_o, ior_o, iow_o} = 4'h0;
		{ack_o, atn_o, cd_o, io_o} = 4'h0;
	end

	// remaining handshake and phase lines packed as {ack, atn, cd, io}
	task automatic set_phase(input logic [3:0] l);
		@(posedge clk_i);
		{ack_o, atn_o, cd_o, io_o} <= l;
	endtask

	// lines packed as {rst, bsy, sel, req, msg}
	task automatic set_lines(input logic [4:0] l);
		@(posedge clk_i);
		{peer_rst, bsy_o, sel_o, req_o, msg_o} <= l;
	endtask

	task automatic set_data(input logic [7:0] d, input logic p);
		@(posedge clk_i);
		data_o <= d;
		parity_o <= p;
	endtask

	// {eop, dma_ack_in, ior, iow} held together for n cycles, then all dropped at once
	task automatic dma_cycle(input logic [3:0] s, input int n);
		@(posedge clk_i);
		{eop_o, dma_ack_in_o, ior_o, iow_o} <= s;
		repeat (n) @(posedge clk_i);
		{eop_o, dma_ack_in_o, ior_o, iow_o} <= 4'h0;
	endtask
endmodule
`default_nettype wire

// [bench/scsi_interrupt_logic_test.sv]
// self-checking bench for the bus-controller interrupt logic
`timescale 1ns/100ps
`default_nettype none
module scsi_interrupt_logic_test;
	localparam logic [7:0] m_dma = 8'h01 << scsi_irq_pkg::MODE_DMA;
	localparam logic [7:0] m_mon = 8'h01 << scsi_irq_pkg::MODE_MON_BSY;
	localparam logic [7:0] m_eod = 8'h01 << scsi_irq_pkg::MODE_EOD_EN;
	localparam logic [7:0] m_par = 8'h01 << scsi_irq_pkg::MODE_PAR_EN;
	localparam logic [7:0] m_tgt = 8'h01 << scsi_irq_pkg::MODE_TGT;
	localparam logic [7:0] a_mode = scsi_irq_pkg::OFF_MODE, a_icmd = scsi_irq_pkg::OFF_INIT_CMD;
	localparam logic [7:0] a_tgt = scsi_irq_pkg::OFF_TGT_CMD, a_id = scsi_irq_pkg::OFF_ID_SELECT;
	localparam logic [7:0] a_st = scsi_irq_pkg::OFF_DMA_STAT, a_clr = scsi_irq_pkg::OFF_IRQ_CLEAR;
	localparam int b_eod = scsi_irq_pkg::STAT_EOD, b_par = scsi_irq_pkg::STAT_PARERR;
	localparam int b_irq = scsi_irq_pkg::STAT_IRQ, b_ph = scsi_irq_pkg::STAT_PHASE;
	localparam int b_bsy = scsi_irq_pkg::STAT_BSYERR;
	logic        core_clk_i, arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, data_line_i;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
	logic        rst_line_i, bsy_line_i, req_line_i, sel_line_i, msg_line_i, parity_line_i;
	logic        end_of_process_in_i, dma_ack_in_i, io_read_strobe_i, io_write_strobe_i;
	logic        irq_o, irq_oe_o, rst_drive_o, bus_pins_en_o, data_drive_en_o, req_accept_o;
	logic        ack_line_i, atn_line_i, cd_line_i, io_line_i;
	int          err_total = 0, checked = 0, cyc = 0;

	scsi_interrupt_logic #(.SETTLE_CYC(4), .EOP_MIN_CYC(2)) u_dut (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .rst_line_i(rst_line_i), .bsy_line_i(bsy_line_i),
		.req_line_i(req_line_i), .ack_line_i(ack_line_i), .sel_line_i(sel_line_i),
		.atn_line_i(atn_line_i), .msg_line_i(msg_line_i), .cd_line_i(cd_line_i),
		.io_line_i(io_line_i), .data_line_i(data_line_i), .parity_line_i(parity_line_i),
		.end_of_process_in_i(end_of_process_in_i), .dma_ack_in_i(dma_ack_in_i),
		.io_read_strobe_i(io_read_strobe_i), .io_write_strobe_i(io_write_strobe_i),
		.irq_o(irq_o), .irq_oe_o(irq_oe_o), .rst_drive_o(rst_drive_o),
		.bus_pins_en_o(bus_pins_en_o), .data_drive_en_o(data_drive_en_o),
		.req_accept_o(req_accept_o)
	);

	scsi_peer_model u_peer (
		.clk_i(core_clk_i), .rst_drive_i(rst_drive_o), .rst_line_o(rst_line_i),
		.bsy_o(bsy_line_i), .sel_o(sel_line_i), .req_o(req_line_i), .msg_o(msg_line_i),
		.data_o(data_line_i), .parity_o(parity_line_i), .ack_o(ack_line_i),
		.atn_o(atn_line_i), .cd_o(cd_line_i), .io_o(io_line_i), .eop_o(end_of_process_in_i),
		.dma_ack_in_o(dma_ack_in_i), .ior_o(io_read_strobe_i), .iow_o(io_write_strobe_i)
	);

	initial begin
		core_clk_i = 1'h0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask

	// handshake flags are taken at the falling edge; nothing changes before the next rise
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic a_go, w_go, b_go;
		@(posedge core_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge core_clk_i);
			a_go = s_axi_awvalid & s_axi_awready;
			w_go = s_axi_wvalid & s_axi_wready;
			b_go = s_axi_bvalid;
			@(posedge core_clk_i);
			if (a_go) s_axi_awvalid <= 1'h0;
			if (w_go) s_axi_wvalid <= 1'h0;
		end while (!b_go);
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		logic a_go, r_go;
		@(posedge core_clk_i);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(negedge core_clk_i);
			a_go = s_axi_arvalid & s_axi_arready;
			r_go = s_axi_rvalid;
			rd_q = s_axi_rdata;
			rd_resp = s_axi_rresp;
			@(posedge core_clk_i);
			if (a_go) s_axi_arvalid <= 1'h0;
		end while (!r_go);
		s_axi_rready <= 1'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input int b, input logic e);
		rd(a);
		chk(rd_q[b], e);
	endtask

	initial begin
		arst_n_i = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h1;
		repeat (2) @(posedge core_clk_i);
		arst_n_i <= 1'h1;
		idle(1);
		chk(irq_o, 1'h0);
		chk(irq_oe_o, 1'h1);
		rd(8'h18);
		chk(rd_resp, 2'h2);
		u_peer.set_lines(5'h18);
		idle(3);
		chk(irq_o, 1'h1);
		rdchk(scsi_irq_pkg::OFF_CTRL_VIEW, scsi_irq_pkg::VIEW_RST, 1'h1);
		u_peer.set_lines(5'h08);
		rdchk(scsi_irq_pkg::OFF_CTRL_VIEW, scsi_irq_pkg::VIEW_RST, 1'h0);
		rd(a_st);
		chk(rd_q[b_irq], 1'h1);
		chk(rd_q[7:0] & 8'ha4, 8'h00);
		rd(a_clr);
		idle(1);
		chk(irq_o, 1'h0);
		wr(a_icmd, 8'h80);
		idle(3);
		chk(rst_drive_o, 1'h1);
		chk(irq_o, 1'h1);
		wr(a_icmd, 8'h40);
		idle(1);
		chk(irq_oe_o, 1'h0);
		wr(a_icmd, 8'h00);
		rd(a_clr);
		idle(1);
		chk(irq_oe_o, 1'h1);
		chk(irq_o, 1'h0);
		// req and msg up while the target phase register holds 000
		u_peer.set_lines(5'h0b);
		u_peer.set_data(8'h00, 1'h0);
		idle(3);
		chk(data_drive_en_o, 1'h0);
		chk(req_accept_o, 1'h0);
		chk(irq_o, 1'h0);
		rdchk(a_st, b_ph, 1'h0);
		wr(a_mode, m_dma);
		idle(2);
		chk(irq_o, 1'h1);
		rdchk(a_st, b_par, 1'h0);
		wr(a_tgt, 8'h04);
		idle(1);
		chk(req_accept_o, 1'h1);
		chk(data_drive_en_o, 1'h1);
		rdchk(a_st, b_ph, 1'h1);
		u_peer.set_phase(4'h2);
		rdchk(a_st, b_ph, 1'h0);
		u_peer.set_phase(4'h0);
		rd(a_clr);
		wr(a_mode, m_dma | m_par);
		idle(2);
		chk(irq_o, 1'h1);
		rdchk(a_st, b_par, 1'h1);
		u_peer.set_data(8'h00, 1'h1);
		rd(a_clr);
		rdchk(a_st, b_par, 1'h0);
		// target mode: bad data counts only while ack is up
		wr(a_mode, m_dma | m_par | m_tgt);
		u_peer.set_data(8'h00, 1'h0);
		rdchk(a_st, b_par, 1'h0);
		u_peer.set_phase(4'hc);
		rd(a_st);
		chk(rd_q[b_par], 1'h1);
		chk(rd_q[1:0], 2'h3);
		u_peer.set_data(8'h00, 1'h1);
		u_peer.set_phase(4'h0);
		rd(a_clr);
		u_peer.set_lines(5'h09);
		wr(a_mode, m_dma);
		u_peer.dma_cycle(4'hc, 4);
		rdchk(a_st, b_eod, 1'h0);
		u_peer.dma_cycle(4'he, 1);
		rdchk(a_st, b_eod, 1'h0);
		u_peer.dma_cycle(4'he, 3);
		rdchk(a_st, b_eod, 1'h1);
		idle(0);
		chk(irq_o, 1'h0);
		rd(a_clr);
		rdchk(a_st, b_eod, 1'h1);
		wr(a_mode, 8'h00);
		rdchk(a_st, b_eod, 1'h0);
		wr(a_mode, m_dma | m_eod);
		u_peer.dma_cycle(4'hd, 3);
		idle(2);
		chk(irq_o, 1'h1);
		wr(a_mode, 8'h00);
		rd(a_clr);
		// busy dropped with monitoring off, then selection attempts
		u_peer.set_lines(5'h00);
		u_peer.set_data(8'h04, 1'h0);
		idle(10);
		chk(irq_o, 1'h0);
		rdchk(a_st, b_bsy, 1'h0);
		u_peer.set_lines(5'h04);
		idle(3);
		chk(irq_o, 1'h0);
		u_peer.set_lines(5'h00);
		wr(a_id, 8'h02);
		u_peer.set_lines(5'h04);
		idle(3);
		chk(irq_o, 1'h0);
		u_peer.set_lines(5'h00);
		wr(a_id, 8'h04);
		u_peer.set_phase(4'h1);
		u_peer.set_lines(5'h04);
		idle(3);
		chk(irq_o, 1'h1);
		rd(scsi_irq_pkg::OFF_CTRL_VIEW);
		chk(rd_q[2:1], 2'h3);
		u_peer.set_phase(4'h0);
		u_peer.set_lines(5'h08);
		rd(a_clr);
		wr(a_icmd, 8'h3f);
		wr(a_mode, m_dma | m_mon);
		u_peer.set_lines(5'h00);
		idle(2);
		chk(irq_o, 1'h0);
		idle(6);
		chk(irq_o, 1'h1);
		chk(bus_pins_en_o, 1'h0);
		rdchk(a_st, b_bsy, 1'h1);
		rdchk(a_mode, scsi_irq_pkg::MODE_DMA, 1'h0);
		rd(a_icmd);
		chk(rd_q[5:0], 6'h00);
		rd(a_clr);
		rdchk(a_st, b_bsy, 1'h0);
		finish_test();
	end
endmodule
`default_nettype wire
